// *** include/spcd_pkg.sv ***
// Constants and types of the step pulse command decoder.
// Assumes one 20 MHz clock and a plain strobe register port.
package spcd_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int GEAR_W = 16;
	localparam int RES_W  = 14;
	localparam int POS_W  = 32;

	//////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PULSE_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CONFIG     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_GEAR_NUM   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GEAR_DEN1  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_GEAR_DEN2  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_GEAR_DEN3  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_GEAR_DEN4  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_DONE_OFS   = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_DONE_RANGE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_RESOLUTION = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_CMD_POS    = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_HOME_POS   = 8'h30;

	// Config field positions
	localparam int CFG_EXCITE_ZERO = 0;
	localparam int CFG_AUTO_RETURN = 1;
	localparam int CFG_ROT_CCW     = 2;
	localparam int CFG_ABN_WARN    = 3;
	localparam int CFG_CEN_NC      = 4;
	localparam int CFG_W           = 5;

	// Status field positions
	localparam int ST_GEAR_WARN  = 0;
	localparam int ST_GEAR_ALARM = 1;
	localparam int ST_ABN_WARN   = 2;
	localparam int ST_DONE       = 3;
	localparam int ST_EXCITED    = 4;
	localparam int ST_RETURNING  = 5;
	localparam int ST_W          = 6;

	//////////////////////////////////////////////////////////////////////
	// Resolution arithmetic
	localparam logic [31:0] RES_SCALE = 32'h0000_03E8;
	localparam logic [31:0] RES_MIN   = 32'h0000_0064;
	localparam logic [31:0] RES_MAX   = 32'h0000_2710;

	// Reset values: 1000, 10000, 500, 5000 P/R
	localparam logic [GEAR_W-1:0] GEAR_NUM_RST  = 16'h000A;
	localparam logic [GEAR_W-1:0] GEAR_DEN1_RST = 16'h000A;
	localparam logic [GEAR_W-1:0] GEAR_DEN2_RST = 16'h0001;
	localparam logic [GEAR_W-1:0] GEAR_DEN3_RST = 16'h0014;
	localparam logic [GEAR_W-1:0] GEAR_DEN4_RST = 16'h0002;
	localparam logic [CFG_W-1:0]  CONFIG_RST    = 5'h00;
	localparam logic [15:0]       DONE_OFS_RST  = 16'h0000;
	localparam logic [15:0]       DONE_RNG_RST  = 16'h0002;

	typedef enum logic [2:0] {
		PM_SWITCH, PM_SINGLE_LOW, PM_SINGLE_HIGH,
		PM_DUAL_LOW, PM_DUAL_HIGH, PM_QUAD
	} spcd_pmode_type;

	localparam spcd_pmode_type PULSE_MODE_RST = PM_SWITCH;

	typedef enum logic [1:0] {DM_SINGLE, DM_DUAL, DM_QUAD} spcd_dmode_type;

	typedef enum logic [1:0] {EX_OFF, EX_SEEK, EX_ON, EX_RETURN} spcd_exc_type;
endpackage

// *** logic/spcd_pulse_decoder.sv ***
// Turns step inputs into one-cycle step events with a direction.
// Assumes inputs already synchronous to clk; mode held stable between loads.
module spcd_pulse_decoder (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire spcd_pkg::spcd_dmode_type mode,
	input  wire logic                    act_high,
	input  wire logic                    step_pulse_in,
	input  wire logic                    rotation_sense_in,
	input  wire logic                    forward_pulse_in,
	input  wire logic                    reverse_pulse_in,
	output logic                         step_out,
	output logic                         fwd_out
);
	import spcd_pkg::*;

	logic pulse_a;
	logic pulse_b;
	logic sense;
	logic a_prev_r;
	logic b_prev_r;
	logic a_edge;
	logic b_edge;

	// Normalise polarity so the active level is always 1
	assign pulse_a = act_high ~^ (mode == DM_SINGLE ? step_pulse_in : forward_pulse_in);
	assign pulse_b = act_high ~^ reverse_pulse_in;
	assign sense   = act_high ~^ rotation_sense_in;
	assign a_edge  = pulse_a & ~a_prev_r;
	assign b_edge  = pulse_b & ~b_prev_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			a_prev_r <= 1'b0;
			b_prev_r <= 1'b0;
		end else begin
			a_prev_r <= pulse_a;
			b_prev_r <= pulse_b;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			step_out <= 1'b0;
			fwd_out  <= 1'b0;
		end else begin
			case (mode)
				DM_SINGLE: begin
					step_out <= a_edge;
					fwd_out  <= sense;
				end
				DM_DUAL: begin
					// Both edges together cancel; controller must not do it
					step_out <= a_edge ^ b_edge;
					fwd_out  <= a_edge;
				end
				default: begin
					// Four counts per cycle; B lagging A means forward
					step_out <= (pulse_a ^ a_prev_r) | (pulse_b ^ b_prev_r);
					fwd_out  <= ~(a_prev_r ^ pulse_b);
				end
			endcase
		end
	end
endmodule

// *** logic/spcd_decoder.sv ***
// Command front end: pulse decoding, resolution, excitation, done output.
// Assumes synchronous pins, a feedback position and a strobe register port.
module spcd_decoder (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic [spcd_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [spcd_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic [spcd_pkg::DATA_W-1:0]       reg_rdata,
	input  wire logic                         power_cycle_in,
	input  wire logic                         resolution_bank_second,
	input  wire logic                         divider_switch_high,
	input  wire logic                         dual_pulse_setting,
	input  wire logic                         resolution_select_in,
	input  wire logic                         step_pulse_in,
	input  wire logic                         rotation_sense_in,
	input  wire logic                         forward_pulse_in,
	input  wire logic                         reverse_pulse_in,
	input  wire logic                         current_enable_in,
	input  wire logic                         shaft_release_in,
	input  wire logic                         phase_origin_flag,
	input  wire logic                         home_set_in,
	input  wire logic                         home_return_req_in,
	input  wire logic [spcd_pkg::POS_W-1:0]   motor_position_in,
	output logic                              motor_step_out,
	output logic                              motor_cw_out,
	output logic [spcd_pkg::RES_W-1:0]        resolution_out,
	output logic                              gear_warning_out,
	output logic                              gear_alarm_out,
	output logic                              abnormal_data_warning_out,
	output logic                              home_return_start_out,
	output logic                              excite_out,
	output logic                              origin_seek_out,
	output logic                              auto_return_out,
	output logic [spcd_pkg::POS_W-1:0]        return_target_out,
	output logic                              positioning_done_out
);
	import spcd_pkg::*;

	function automatic logic [31:0] res_calc(input logic [GEAR_W-1:0] num,
	                                         input logic [GEAR_W-1:0] den);
		logic [31:0] prod;
		prod = RES_SCALE * {16'h0000, num};
		if (den == 16'h0000) begin
			res_calc = 32'h0000_0000;
		end else begin
			res_calc = prod / {16'h0000, den};
		end
	endfunction

	function automatic logic res_ok(input logic [31:0] res);
		res_ok = (res >= RES_MIN) && (res <= RES_MAX);
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Stored parameters, written by software at any time
	spcd_pmode_type    pmode_r;
	logic [CFG_W-1:0]  cfg_r;
	logic [GEAR_W-1:0] num_r;
	logic [GEAR_W-1:0] den_r [4];
	logic [15:0]       dofs_r;
	logic [15:0]       drng_r;

	// Effective copies, loaded only at power-up
	spcd_pmode_type    pmode_e_r;
	logic [CFG_W-1:0]  cfg_e_r;
	logic [15:0]       dofs_e_r;
	logic [15:0]       drng_e_r;
	logic              bank2_e_r;
	logic              div_e_r;
	logic              sw_dual_e_r;
	logic [RES_W-1:0]  res_e_r [4];
	logic              boot_r;
	logic              load;

	logic              gear_warn_r;
	logic              gear_alarm_r;
	logic              abn_warn_r;
	logic              sel_prev_r;
	logic              home_prev_r;
	logic [POS_W-1:0]  home_pos_r;
	logic [POS_W-1:0]  cmd_pos_r;
	logic [POS_W-1:0]  stop_pos_r;
	spcd_exc_type      exc_r;
	logic              first_done_r;
	logic              done_r;
	logic              on_cond;
	logic              any_bad;
	logic [31:0]       res_now [4];

	spcd_dmode_type    dmode;
	logic              act_high;
	logic              step;
	logic              fwd;

	assign load = boot_r | power_cycle_in;

	//////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pmode_r  <= PULSE_MODE_RST;
			cfg_r    <= CONFIG_RST;
			num_r    <= GEAR_NUM_RST;
			den_r[0] <= GEAR_DEN1_RST;
			den_r[1] <= GEAR_DEN2_RST;
			den_r[2] <= GEAR_DEN3_RST;
			den_r[3] <= GEAR_DEN4_RST;
			dofs_r   <= DONE_OFS_RST;
			drng_r   <= DONE_RNG_RST;
		end else if (reg_wr) begin
			if (reg_addr == OFS_PULSE_MODE) begin
				pmode_r <= spcd_pmode_type'(reg_wdata[2:0]);
			end else if (reg_addr == OFS_CONFIG) begin
				cfg_r <= reg_wdata[CFG_W-1:0];
			end else if (reg_addr == OFS_GEAR_NUM) begin
				num_r <= reg_wdata[GEAR_W-1:0];
			end else if (reg_addr == OFS_GEAR_DEN1) begin
				den_r[0] <= reg_wdata[GEAR_W-1:0];
			end else if (reg_addr == OFS_GEAR_DEN2) begin
				den_r[1] <= reg_wdata[GEAR_W-1:0];
			end else if (reg_addr == OFS_GEAR_DEN3) begin
				den_r[2] <= reg_wdata[GEAR_W-1:0];
			end else if (reg_addr == OFS_GEAR_DEN4) begin
				den_r[3] <= reg_wdata[GEAR_W-1:0];
			end else if (reg_addr == OFS_DONE_OFS) begin
				dofs_r <= reg_wdata[15:0];
			end else if (reg_addr == OFS_DONE_RANGE) begin
				drng_r <= reg_wdata[15:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Power-up sampling of switches, parameters and resolutions
	always_comb begin
		any_bad = 1'b0;
		for (int i = 0; i < 4; i++) begin
			res_now[i] = res_calc(num_r, den_r[i]);
			any_bad    = any_bad | ~res_ok(res_now[i]);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			boot_r <= 1'b1;
		end else begin
			boot_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pmode_e_r   <= PULSE_MODE_RST;
			cfg_e_r     <= CONFIG_RST;
			dofs_e_r    <= DONE_OFS_RST;
			drng_e_r    <= DONE_RNG_RST;
			bank2_e_r   <= 1'b0;
			div_e_r     <= 1'b0;
			sw_dual_e_r <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				res_e_r[i] <= '0;
			end
		end else if (load) begin
			// Nothing here follows later writes or switch moves
			pmode_e_r   <= pmode_r;
			cfg_e_r     <= cfg_r;
			dofs_e_r    <= dofs_r;
			drng_e_r    <= drng_r;
			bank2_e_r   <= resolution_bank_second;
			div_e_r     <= divider_switch_high;
			sw_dual_e_r <= dual_pulse_setting;
			for (int i = 0; i < 4; i++) begin
				res_e_r[i] <= res_ok(res_now[i]) ? res_now[i][RES_W-1:0] : '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gear_warn_r  <= 1'b0;
			gear_alarm_r <= 1'b0;
		end else if (load) begin
			gear_warn_r  <= any_bad;
			gear_alarm_r <= gear_warn_r;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Resolution selection; index is divider then select input, select forced high in bank two
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			resolution_out <= '0;
		end else if (bank2_e_r) begin
			resolution_out <= res_e_r[{div_e_r, 1'b1}];
		end else begin
			resolution_out <= res_e_r[{div_e_r, resolution_select_in}];
		end
	end

	// Abnormal data warning: set wins over the home set clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel_prev_r  <= 1'b0;
			home_prev_r <= 1'b0;
			abn_warn_r  <= 1'b0;
		end else begin
			sel_prev_r  <= resolution_select_in;
			home_prev_r <= home_set_in;
			if (resolution_select_in & ~sel_prev_r & cfg_e_r[CFG_ABN_WARN]) begin
				abn_warn_r <= 1'b1;
			end else if (home_set_in & ~home_prev_r) begin
				abn_warn_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			home_return_start_out <= 1'b0;
		end else begin
			home_return_start_out <= home_return_req_in & ~abn_warn_r
			                         & ~(resolution_select_in & ~sel_prev_r & cfg_e_r[CFG_ABN_WARN]);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			home_pos_r <= '0;
		end else if (load | (home_set_in & ~home_prev_r)) begin
			home_pos_r <= motor_position_in;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Pulse decoding
	always_comb begin
		case (pmode_e_r)
			PM_SWITCH: begin
				dmode    = sw_dual_e_r ? DM_DUAL : DM_SINGLE;
				act_high = 1'b0;
			end
			PM_SINGLE_LOW: begin
				dmode    = DM_SINGLE;
				act_high = 1'b0;
			end
			PM_SINGLE_HIGH: begin
				dmode    = DM_SINGLE;
				act_high = 1'b1;
			end
			PM_DUAL_LOW: begin
				dmode    = DM_DUAL;
				act_high = 1'b0;
			end
			PM_DUAL_HIGH: begin
				dmode    = DM_DUAL;
				act_high = 1'b1;
			end
			default: begin
				dmode    = DM_QUAD;
				act_high = 1'b1;
			end
		endcase
	end

	spcd_pulse_decoder u_dec (
		.clk               (clk),
		.sys_rst           (sys_rst),
		.mode              (dmode),
		.act_high          (act_high),
		.step_pulse_in     (step_pulse_in),
		.rotation_sense_in (rotation_sense_in),
		.forward_pulse_in  (forward_pulse_in),
		.reverse_pulse_in  (reverse_pulse_in),
		.step_out          (step),
		.fwd_out           (fwd)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_pos_r      <= '0;
			motor_step_out <= 1'b0;
			motor_cw_out   <= 1'b0;
		end else begin
			motor_step_out <= step;
			if (step) begin
				motor_cw_out <= fwd ^ cfg_e_r[CFG_ROT_CCW];
			end
			if (load) begin
				cmd_pos_r <= motor_position_in;
			end else if (step) begin
				cmd_pos_r <= fwd ? cmd_pos_r + 32'h0000_0001 : cmd_pos_r - 32'h0000_0001;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Excitation and automatic return
	assign on_cond = (current_enable_in ^ cfg_e_r[CFG_CEN_NC]) & ~shaft_release_in;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exc_r        <= EX_OFF;
			first_done_r <= 1'b0;
			stop_pos_r   <= '0;
		end else if (load) begin
			exc_r        <= EX_OFF;
			first_done_r <= 1'b0;
			stop_pos_r   <= motor_position_in;
		end else begin
			case (exc_r)
				EX_OFF: begin
					if (on_cond) begin
						first_done_r <= 1'b1;
						if (!first_done_r) begin
							// Normally closed enable is already on here
							if (cfg_e_r[CFG_EXCITE_ZERO] | cfg_e_r[CFG_CEN_NC]) begin
								exc_r <= EX_SEEK;
							end else begin
								exc_r <= EX_ON;
							end
						end else if (cfg_e_r[CFG_AUTO_RETURN]) begin
							exc_r <= EX_RETURN;
						end else begin
							exc_r <= EX_ON;
						end
					end
				end
				EX_SEEK: begin
					if (!on_cond) begin
						exc_r <= EX_OFF;
					end else if (phase_origin_flag) begin
						exc_r <= EX_ON;
					end
				end
				EX_ON: begin
					if (!on_cond) begin
						exc_r      <= EX_OFF;
						stop_pos_r <= motor_position_in;
					end
				end
				default: begin
					if (!on_cond) begin
						exc_r <= EX_OFF;
					end else if (motor_position_in == stop_pos_r) begin
						exc_r <= EX_ON;
					end
				end
			endcase
		end
	end

	assign excite_out        = exc_r != EX_OFF;
	assign origin_seek_out   = exc_r == EX_SEEK;
	assign auto_return_out   = exc_r == EX_RETURN;
	assign return_target_out = stop_pos_r;

	//////////////////////////////////////////////////////////////////////
	// Positioning done, with offset removed before the range test
	logic signed [POS_W-1:0] dev_adj;
	assign dev_adj = $signed(cmd_pos_r - motor_position_in)
	                 - $signed({{(POS_W-16){dofs_e_r[15]}}, dofs_e_r});

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (exc_r == EX_ON)
			          && (dev_adj <= $signed({16'h0000, drng_e_r}))
			          && (dev_adj >= -$signed({16'h0000, drng_e_r}));
		end
	end

	assign positioning_done_out      = done_r;
	assign gear_warning_out          = gear_warn_r;
	assign gear_alarm_out            = gear_alarm_r;
	assign abnormal_data_warning_out = abn_warn_r;

	//////////////////////////////////////////////////////////////////////
	// Register reads; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == OFS_PULSE_MODE) begin
				reg_rdata <= {29'h0000_0000, pmode_r};
			end else if (reg_addr == OFS_CONFIG) begin
				reg_rdata <= {27'h000_0000, cfg_r};
			end else if (reg_addr == OFS_GEAR_NUM) begin
				reg_rdata <= {16'h0000, num_r};
			end else if (reg_addr == OFS_GEAR_DEN1) begin
				reg_rdata <= {16'h0000, den_r[0]};
			end else if (reg_addr == OFS_GEAR_DEN2) begin
				reg_rdata <= {16'h0000, den_r[1]};
			end else if (reg_addr == OFS_GEAR_DEN3) begin
				reg_rdata <= {16'h0000, den_r[2]};
			end else if (reg_addr == OFS_GEAR_DEN4) begin
				reg_rdata <= {16'h0000, den_r[3]};
			end else if (reg_addr == OFS_DONE_OFS) begin
				reg_rdata <= {16'h0000, dofs_r};
			end else if (reg_addr == OFS_DONE_RANGE) begin
				reg_rdata <= {16'h0000, drng_r};
			end else if (reg_addr == OFS_STATUS) begin
				reg_rdata <= {26'h000_0000, exc_r == EX_RETURN, exc_r != EX_OFF,
				              done_r, abn_warn_r, gear_alarm_r, gear_warn_r};
			end else if (reg_addr == OFS_RESOLUTION) begin
				reg_rdata <= {18'h0_0000, resolution_out};
			end else if (reg_addr == OFS_CMD_POS) begin
				reg_rdata <= cmd_pos_r;
			end else if (reg_addr == OFS_HOME_POS) begin
				reg_rdata <= home_pos_r;
			end else begin
				reg_rdata <= '0;
			end
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule

// *** bench/spcd_decoder_chk.sv ***
// Port-level timing checks for the step pulse command decoder.
// Assumes spcd_pkg is compiled first; bound to every decoder instance.
module spcd_decoder_chk (
	input wire logic	clk,
	input wire logic	sys_rst,
	input wire logic	power_cycle_in,
	input wire logic	phase_origin_flag,
	input wire logic	home_return_req_in,
	input wire logic [spcd_pkg::POS_W-1:0]	motor_position_in,
	input wire logic	motor_step_out,
	input wire logic [spcd_pkg::RES_W-1:0]	resolution_out,
	input wire logic	gear_warning_out,
	input wire logic	gear_alarm_out,
	input wire logic	abnormal_data_warning_out,
	input wire logic	home_return_start_out,
	input wire logic	origin_seek_out,
	input wire logic	auto_return_out,
	input wire logic [spcd_pkg::POS_W-1:0]	return_target_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import spcd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	a_step_one_cycle: assert property (motor_step_out |=> !motor_step_out)
		else $error("step pulse longer than one cycle");
	a_res_window: assert property (
		resolution_out != '0 |-> resolution_out >= RES_MIN && resolution_out <= RES_MAX)
		else $error("resolution outside legal window");
	// Loads land one or two edges after their cause
	a_warn_at_load: assert property ($changed(gear_warning_out) |->
		$past(power_cycle_in) || $past(power_cycle_in, 2) || $past(sys_rst) || $past(sys_rst, 2))
		else $error("gear warning moved outside a load");
	a_alarm_cause: assert property ($rose(gear_alarm_out) |->
		$past(gear_warning_out) || $past(gear_warning_out, 2))
		else $error("gear alarm without earlier warning");
	a_home_blocked: assert property (abnormal_data_warning_out |-> !home_return_start_out)
		else $error("home return passed during warning");
	a_home_cause: assert property (home_return_start_out |-> $past(home_return_req_in))
		else $error("home return start without request");
	a_seek_exit: assert property (origin_seek_out && phase_origin_flag |=> !origin_seek_out)
		else $error("origin seek held past phase origin");
	a_return_end: assert property (
		auto_return_out && motor_position_in == return_target_out |=> !auto_return_out)
		else $error("auto return held at target");
	c_step: cover property (motor_step_out);
	c_alarm: cover property (gear_alarm_out);
	c_return: cover property (auto_return_out);
endmodule

bind spcd_decoder spcd_decoder_chk chk (.clk, .sys_rst, .power_cycle_in, .phase_origin_flag,
	.home_return_req_in, .motor_position_in, .motor_step_out, .resolution_out, .gear_warning_out,
	.gear_alarm_out, .abnormal_data_warning_out, .home_return_start_out, .origin_seek_out,
	.auto_return_out, .return_target_out);

// *** bench/spcd_pulse_gen.sv ***
// Behavioural pulse generator in the place of the external controller.
// Assumes its tasks are called from one bench process, one at a time.
module spcd_pulse_gen (
	input  wire logic	clk,
	output logic	step_pulse_in,
	output logic	rotation_sense_in,
	output logic	forward_pulse_in,
	output logic	reverse_pulse_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	act_r = 1'b0;
	initial {step_pulse_in, rotation_sense_in, forward_pulse_in, reverse_pulse_in} = 4'hF;
	////////////////////////////////////////////////////////////
	// Three cycles per level, above the two-cycle minimum
	task automatic hold();
		repeat (3) @(posedge clk);
	endtask
	task automatic set_idle(logic act);
		@(posedge clk);
		act_r <= act;
		{step_pulse_in, rotation_sense_in, forward_pulse_in, reverse_pulse_in} <= {4{~act}};
		hold();
	endtask
	task automatic single(logic fwd);
		@(posedge clk);
		rotation_sense_in <= ~(fwd ^ act_r);
		hold();
		step_pulse_in <= act_r;
		hold();
		step_pulse_in <= ~act_r;
		hold();
	endtask
	task automatic dual(logic fwd);
		@(posedge clk);
		forward_pulse_in <= fwd ? act_r : ~act_r;
		reverse_pulse_in <= fwd ? ~act_r : act_r;
		hold();
		{forward_pulse_in, reverse_pulse_in} <= {2{~act_r}};
		hold();
	endtask
	// Forward toggles the first channel first, so the second lags
	task automatic quad(logic fwd);
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			if ((i % 2 == 0) == fwd)
				forward_pulse_in <= ~forward_pulse_in;
			else
				reverse_pulse_in <= ~reverse_pulse_in;
			hold();
		end
	endtask
endmodule

// *** bench/spcd_decoder_tb.sv ***
// Self-checking bench of the step pulse command decoder.
// Assumes spcd_pkg, the decoder, its checker and the pulse generator.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module spcd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spcd_pkg::*;
	logic	clk = 1'b0;
	logic	sys_rst = 1'b1;
	logic [ADDR_W-1:0]	reg_addr;
	logic [DATA_W-1:0]	reg_wdata, reg_rdata, p0, p1;
	logic	reg_wr, reg_rd, power_cycle_in, resolution_bank_second, divider_switch_high;
	logic	dual_pulse_setting, resolution_select_in, current_enable_in, shaft_release_in;
	logic	phase_origin_flag, home_set_in, home_return_req_in, motor_step_out, motor_cw_out;
	logic	gear_warning_out, gear_alarm_out, abnormal_data_warning_out, home_return_start_out;
	logic	excite_out, origin_seek_out, auto_return_out, positioning_done_out;
	logic	step_pulse_in, rotation_sense_in, forward_pulse_in, reverse_pulse_in;
	logic [POS_W-1:0]	motor_position_in, return_target_out;
	logic [RES_W-1:0]	resolution_out;
	int	fails = 0;
	int	cmp_count = 0;
	spcd_decoder DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_cycle_in,
		.resolution_bank_second, .divider_switch_high, .dual_pulse_setting, .resolution_select_in,
		.step_pulse_in, .rotation_sense_in, .forward_pulse_in, .reverse_pulse_in, .current_enable_in,
		.shaft_release_in, .phase_origin_flag, .home_set_in, .home_return_req_in, .motor_position_in,
		.motor_step_out, .motor_cw_out, .resolution_out, .gear_warning_out, .gear_alarm_out,
		.abnormal_data_warning_out, .home_return_start_out, .excite_out, .origin_seek_out,
		.auto_return_out, .return_target_out, .positioning_done_out);
	spcd_pulse_gen gen (.clk, .step_pulse_in, .rotation_sense_in, .forward_pulse_in, .reverse_pulse_in);
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic wt(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic pc();
		@(posedge clk);
		power_cycle_in <= 1'b1;
		@(posedge clk);
		power_cycle_in <= 1'b0;
		wt(3);
	endtask
	task automatic step(int i, logic f);
		if (i == 5)
			gen.quad(f);
		else if (i >= 3)
			gen.dual(f);
		else
			gen.single(f);
	endtask
	task automatic final_report();
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	localparam logic [ADDR_W-1:0] RO_T [7] = '{OFS_GEAR_NUM, OFS_GEAR_DEN1, OFS_GEAR_DEN2, OFS_GEAR_DEN3,
		OFS_GEAR_DEN4, OFS_DONE_RANGE, 8'h40};
	localparam logic [DATA_W-1:0] RV_T [7] = '{32'h0000_000A, 32'h0000_000A, 32'h0000_0001,
		32'h0000_0014, 32'h0000_0002, 32'h0000_0002, 32'h0000_0000};
	initial begin
		{reg_wr, reg_rd, power_cycle_in, resolution_bank_second, divider_switch_high, dual_pulse_setting,
			resolution_select_in, current_enable_in, shaft_release_in, phase_origin_flag, home_set_in,
			home_return_req_in, reg_addr, reg_wdata, motor_position_in} = '0;
		wt(6);
		sys_rst <= 1'b0;
		wt(3);
		`CHK("res default", 14'h03E8, resolution_out)
		for (int k = 0; k < 7; k++) begin
			rd(RO_T[k], p0);
			`CHK("reset value", RV_T[k], p0)
		end
		resolution_select_in <= 1'b1;
		wt(3);
		`CHK("res select", 14'h2710, resolution_out)
		{resolution_bank_second, divider_switch_high, resolution_select_in} <= 3'h6;
		wt(3);
		`CHK("res unloaded", 14'h03E8, resolution_out)
		pc();
		`CHK("res bank two", 14'h1388, resolution_out)
		resolution_bank_second <= 1'b0;
		pc();
		`CHK("res divider", 14'h01F4, resolution_out)
		// Denominator 200 gives 50 P/R, below the window
		wr(OFS_GEAR_DEN3, 32'h0000_00C8);
		wt(2);
		`CHK("warn unloaded", 1'b0, gear_warning_out)
		pc();
		`CHK("gear warn", 1'b1, gear_warning_out)
		`CHK("res refused", 14'h0000, resolution_out)
		`CHK("alarm early", 1'b0, gear_alarm_out)
		pc();
		`CHK("gear alarm", 1'b1, gear_alarm_out)
		wr(OFS_GEAR_DEN3, 32'h0000_0014);
		wr(OFS_DONE_OFS, 32'h0000_0003);
		pc();
		pc();
		`CHK("alarm gone", 1'b0, gear_alarm_out)
		current_enable_in <= 1'b1;
		wt(4);
		`CHK("excite here", 2'h2, {excite_out, origin_seek_out})
		rd(OFS_CMD_POS, p0);
		motor_position_in <= p0 - 32'h0000_0005;
		wt(4);
		`CHK("done edge", 1'b1, positioning_done_out)
		motor_position_in <= p0;
		wt(4);
		`CHK("done off", 1'b0, positioning_done_out)
		motor_position_in <= 32'h0000_0123;
		wt(3);
		current_enable_in <= 1'b0;
		wt(4);
		`CHK("stop pos", 32'h0000_0123, return_target_out)
		for (int i = 0; i < 7; i++) begin
			dual_pulse_setting <= (i == 6);
			wr(OFS_PULSE_MODE, (i == 6) ? 32'h0000_0000 : 32'(i));
			pc();
			gen.set_idle(i == 2 || i == 4 || i == 5);
			wt(4);
			rd(OFS_CMD_POS, p0);
			repeat (2) step(i, 1'b1);
			`CHK("cw fwd", 1'b1, motor_cw_out)
			step(i, 1'b0);
			`CHK("cw rev", 1'b0, motor_cw_out)
			rd(OFS_CMD_POS, p1);
			`CHK("cmd delta", (i == 5) ? 32'h0000_0004 : 32'h0000_0001, p1 - p0)
		end
		wr(OFS_CONFIG, 32'h0000_0004);
		pc();
		gen.dual(1'b1);
		`CHK("ccw sense", 1'b0, motor_cw_out)
		// Zero-angle start, auto return and abnormal warning at once
		wr(OFS_CONFIG, 32'h0000_000B);
		pc();
		current_enable_in <= 1'b1;
		wt(3);
		`CHK("seek", 2'h3, {excite_out, origin_seek_out})
		phase_origin_flag <= 1'b1;
		wt(3);
		`CHK("seek done", 2'h2, {excite_out, origin_seek_out})
		{phase_origin_flag, current_enable_in} <= 2'h0;
		wt(3);
		motor_position_in <= 32'h0000_0200;
		current_enable_in <= 1'b1;
		wt(3);
		`CHK("returning", 1'b1, auto_return_out)
		motor_position_in <= 32'h0000_0123;
		wt(3);
		`CHK("returned", 2'h2, {excite_out, auto_return_out})
		{resolution_select_in, home_return_req_in} <= 2'h3;
		wt(3);
		`CHK("abn warn", 2'h2, {abnormal_data_warning_out, home_return_start_out})
		{home_set_in, motor_position_in} <= {1'b1, 32'h0000_0456};
		wt(3);
		`CHK("home set", 2'h1, {abnormal_data_warning_out, home_return_start_out})
		rd(OFS_HOME_POS, p0);
		`CHK("home pos", 32'h0000_0456, p0)
		{home_set_in, home_return_req_in, current_enable_in} <= 3'h0;
		motor_position_in <= 32'h0000_0789;
		wr(OFS_CONFIG, 32'h0000_0010);
		pc();
		`CHK("closed start", 1'b1, origin_seek_out)
		rd(OFS_HOME_POS, p0);
		`CHK("boot home", 32'h0000_0789, p0)
		final_report();
	end
	initial begin
		#4_000_000;
		fails++;
		final_report();
	end
endmodule
